/* File: hdl/pwos_defs.vh */
// Constants for the PWM output selection and polarity update block
// Operation
// - Low clear bit selects dead-time low output
// - High clear bit selects dead-time high output
// - Selection clear register write-only at 0x50
// - Four write-only polarity registers from 0x400
// - Polarity writes need group two unprotected
// - Polarity value held in double buffer
// - Invert bit flips comparator output polarity
// - Invert bit set ignores polarity bit
// - Polarity bit picks low or high start
`ifndef PWOS_DEFS_VH
`define PWOS_DEFS_VH
`define PWOS_OSC_ADDR 12'h050
`define PWOS_CMUPD_BASE 12'h400
`define PWOS_CMUPD_STRIDE 12'h020
`define PWOS_LOW_LSB 16
`define PWOS_HIGH_LSB 0
`define PWOS_POL_BIT 9
`define PWOS_INV_BIT 13
`define PWOS_ADDR_W 12
`endif

/* File: hdl/pwos_select_polarity.v */
// Output selection clear and double-buffered channel polarity update
`timescale 1ns/10ps
`include "pwos_defs.vh"
module pwos_select_polarity #(
   parameter NCH = 4
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire soft_protect_group2_flag,
   input wire hard_protect_group2_flag,
   input wire [NCH-1:0] period_end,
   input wire [NCH-1:0] override_low_set,
   input wire [NCH-1:0] override_high_set,
   input wire [NCH-1:0] override_low_value,
   input wire [NCH-1:0] override_high_value,
   input wire [NCH-1:0] deadtime_low_out,
   input wire [NCH-1:0] deadtime_high_out,
   output reg [NCH-1:0] low_side_output,
   output reg [NCH-1:0] high_side_output,
   output reg [NCH-1:0] channel_polarity,
   output wire [NCH-1:0] low_select_override,
   output wire [NCH-1:0] high_select_override
);
   wire wr_access;
   wire osc_hit;
   reg [NCH-1:0] low_sel;
   reg [NCH-1:0] high_sel;
   reg [NCH-1:0] pol_buf;
   reg [NCH-1:0] pol_pend;

   // Single-cycle access phase, never an error
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = 32'h00000000;
   assign wr_access = psel & penable & pwrite;
   assign osc_hit = wr_access && (paddr == `PWOS_OSC_ADDR);
   assign low_select_override = low_sel;
   assign high_select_override = high_sel;

   genvar i;
   generate
      for (i = 0; i < NCH; i = i + 1) begin : g_ch
         wire upd_hit;
         wire inv_req;
         wire [`PWOS_ADDR_W-1:0] ch_addr;
         wire [31:0] ch_addr_full;
         // Full-width sum, then cut to the bus address width on purpose
         assign ch_addr_full = `PWOS_CMUPD_BASE + i * `PWOS_CMUPD_STRIDE;
         assign ch_addr = ch_addr_full[`PWOS_ADDR_W-1:0];
         assign upd_hit = wr_access && (paddr == ch_addr) &&
            !soft_protect_group2_flag && !hard_protect_group2_flag;
         assign inv_req = pwdata[`PWOS_INV_BIT];

         // Selection: clear wins over a set in the same cycle
         always @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               low_sel[i] <= 1'b0;
               high_sel[i] <= 1'b0;
            end else begin
               if (osc_hit && pwdata[`PWOS_LOW_LSB + i]) begin
                  low_sel[i] <= 1'b0;
               end else if (override_low_set[i]) begin
                  low_sel[i] <= 1'b1;
               end
               if (osc_hit && pwdata[`PWOS_HIGH_LSB + i]) begin
                  high_sel[i] <= 1'b0;
               end else if (override_high_set[i]) begin
                  high_sel[i] <= 1'b1;
               end
            end
         end

         // Polarity buffer, applied only at the channel period end
         always @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               pol_buf[i] <= 1'b0;
               pol_pend[i] <= 1'b0;
               channel_polarity[i] <= 1'b0;
            end else begin
               if (upd_hit) begin
                  if (inv_req) begin
                     pol_buf[i] <= ~(pol_pend[i] ? pol_buf[i] : channel_polarity[i]);
                  end else begin
                     pol_buf[i] <= pwdata[`PWOS_POL_BIT];
                  end
                  pol_pend[i] <= 1'b1;
               end else if (period_end[i] && pol_pend[i]) begin
                  channel_polarity[i] <= pol_buf[i];
                  pol_pend[i] <= 1'b0;
               end
            end
         end

         // Registered pin drive from dead-time or override value
         always @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               low_side_output[i] <= 1'b0;
               high_side_output[i] <= 1'b0;
            end else begin
               low_side_output[i] <= low_sel[i] ? override_low_value[i] : deadtime_low_out[i];
               high_side_output[i] <= high_sel[i] ? override_high_value[i] : deadtime_high_out[i];
            end
         end
      end
   endgenerate
endmodule

/* File: verif/pwos_sva.sv */
// Assertions on the selection and polarity block ports
`timescale 1ns/10ps
module pwos_sva (input wire sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr,
   input wire [11:0] paddr, input wire [31:0] pwdata, prdata,
   input wire [3:0] period_end, channel_polarity, low_select_override, high_select_override);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire c = psel && penable && pwrite && paddr == 12'h050;
   wire [3:0] ls = low_select_override, hs = high_select_override, cp = channel_polarity;
   // Bus answer, selection clear and polarity timing
   read_zero_a: assert property (!prdata) else $error("data");
   no_wait_a: assert property (psel |-> pready) else $error("wait");
   no_err_a: assert property (!pslverr) else $error("err");
   low_clr_a: assert property (c |=> !(ls & $past(pwdata[19:16]))) else $error("low");
   high_clr_a: assert property (c |=> !(hs & $past(pwdata[3:0]))) else $error("high");
   low_kept_a: assert property ($fell(ls[0]) |-> $past(c)) else $error("low");
   high_kept_a: assert property ($fell(hs[3]) |-> $past(c)) else $error("high");
   pol_hold_a: assert property (!period_end |=> $stable(cp)) else $error("pol");
endmodule
bind pwos_select_polarity pwos_sva i_pwos_sva (.*);

/* File: verif/pwos_gate.sv */
// Gate driver model latching the switch pins
`timescale 1ns/10ps
module pwos_gate (input wire sys_clk, input wire [3:0] low_side_output, high_side_output,
   output logic [7:0] gate_view);
   // Driver input stage
   always @(posedge sys_clk) gate_view <= {high_side_output, low_side_output};
endmodule

/* File: verif/testbench.sv */
// Bench for the selection and polarity block
`timescale 1ns/10ps
module testbench;
   logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic soft_protect_group2_flag = 0, hard_protect_group2_flag = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [3:0] period_end = 0, override_low_set = 0, override_high_set = 0, channel_polarity;
   logic [3:0] override_low_value = 4'ha, override_high_value = 4'h5, deadtime_low_out = 4'h3;
   logic [3:0] deadtime_high_out = 4'hc, low_side_output, high_side_output;
   logic [3:0] low_select_override, high_select_override;
   logic [7:0] gate_view;
   int n_mismatch = 0, n_tests = 0;
   pwos_select_polarity i_pwos_select_polarity (.*);
   pwos_gate i_pwos_gate (.*);
   // Clock and hang guard
   always #10 sys_clk = ~sys_clk;
   initial begin #50us; n_mismatch++; summarize; end
   // APB transfer held until pready, then two settle cycles
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge sys_clk) penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      chk("rd", prdata, 0);
      {psel, penable} <= 0;
      repeat (2) @(posedge sys_clk);
   endtask
   // Compare and count
   task chk(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin n_mismatch++; $display("wrong value %s exp %h seen %h", n, e, s); end
   endtask
   // Period boundary on all channels
   task pend;
      @(posedge sys_clk) period_end <= 4'hf;
      @(posedge sys_clk) period_end <= 0;
      xfer(0, 12'h400, 0);
   endtask
   // Verdict
   task summarize;
      $display("mismatches %0d checks %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 0;
      @(posedge sys_clk) {override_low_set, override_high_set} <= 8'hff;
      @(posedge sys_clk) {override_low_set, override_high_set} <= 0;
      xfer(1, 12'h050, 32'h0005000a);
      @(negedge sys_clk) chk("gate", gate_view, 8'hdb);
      chk("sel", {high_select_override, low_select_override}, 8'h5a);
      for (int x = 0; x < 4; x++) xfer(1, 12'(12'h400 + 12'h020 * x), 32'h200);
      chk("pol", channel_polarity, 0);
      pend;
      chk("pol", channel_polarity, 4'hf);
      xfer(1, 12'h420, 32'h2200);
      @(posedge sys_clk) soft_protect_group2_flag <= 1;
      xfer(1, 12'h400, 32'h2000);
      @(posedge sys_clk) {soft_protect_group2_flag, hard_protect_group2_flag} <= 2'b01;
      xfer(1, 12'h460, 32'h2000);
      @(posedge sys_clk) hard_protect_group2_flag <= 0;
      xfer(1, 12'h440, 0);
      pend;
      chk("pol", channel_polarity, 4'h9);
      summarize;
   end
endmodule
